// >>> common/dps_pkg.sv
// ----------------------------------------
// shared sizes, codes and port bundles
// ----------------------------------------
package dps_pkg;
  localparam int DPS_NPORTS = 2;
  localparam int DPS_ADDR_W = 16;
  localparam int DPS_LANE_W = 9;
  localparam int DPS_DATA_W = 2 * DPS_LANE_W;
  localparam int DPS_LANE_LO = 0;
  localparam int DPS_LANE_HI = 1;
  localparam logic DPS_MODE_FLOW = 1'h0;
  localparam logic DPS_MODE_PIPE = 1'h1;
  localparam logic [DPS_ADDR_W-1:0] DPS_CNT_RESET = 16'h0000;
  localparam logic [DPS_DATA_W-1:0] DPS_DATA_RESET = 18'h00000;

  typedef struct packed {
    logic [DPS_ADDR_W-1:0] addr;
    logic [DPS_DATA_W-1:0] wdata;
    logic address_strobe_n;
    logic burst_advance_enable_n;
    logic burst_clear_n;
    logic chip_select_active_low;
    logic chip_select_active_high;
    logic write_n;
    logic lower_byte_select_n;
    logic upper_byte_select_n;
    logic output_enable_n;
    logic output_mode_select;
  } dps_port_in_t;

  typedef struct packed {
    logic [DPS_DATA_W-1:0] data_out;
    logic [1:0] data_oe;
    logic power_down;
  } dps_port_out_t;
endpackage

// >>> rtl/dps_sram.sv
`timescale 1ns/1ps
module dps_sram #(
  parameter int ADDR_W = dps_pkg::DPS_ADDR_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire dps_pkg::dps_port_in_t port_in [dps_pkg::DPS_NPORTS],
  output dps_pkg::dps_port_out_t port_out [dps_pkg::DPS_NPORTS]
);
  import dps_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;
  localparam int NP = DPS_NPORTS;
  localparam int DW = DPS_DATA_W;

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  // the collision rule and the lane write checks assume exactly two ports
  // of two lanes each
  if (ADDR_W < 1 || ADDR_W > DPS_ADDR_W) begin : g_bad_addr
    $error("ADDR_W out of range");
  end
  if (NP != 2) begin : g_bad_ports
    $error("only two ports are supported");
  end
  if (DW != 2 * DPS_LANE_W) begin : g_bad_lanes
    $error("data must be two lanes wide");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [DW-1:0] mem [DEPTH];
  dps_port_in_t in_q [NP];
  dps_port_in_t next_in [NP];
  logic [ADDR_W-1:0] cnt [NP];
  logic [ADDR_W-1:0] next_cnt [NP];
  logic [ADDR_W-1:0] acc [NP];
  logic sel [NP];
  logic [DW-1:0] rdata [NP];
  logic [DW-1:0] next_rdata [NP];
  logic rvalid [NP];
  logic next_rvalid [NP];
  logic [1:0] rlanes [NP];
  logic [1:0] next_rlanes [NP];
  logic [DW-1:0] pdata [NP];
  logic [DW-1:0] next_pdata [NP];
  logic pvalid [NP];
  logic next_pvalid [NP];
  logic [1:0] planes [NP];
  logic [1:0] next_planes [NP];

  function automatic logic [ADDR_W-1:0] pick_addr(
    input dps_port_in_t r,
    input logic [ADDR_W-1:0] c
  );
    if (!r.burst_clear_n) begin
      pick_addr = DPS_CNT_RESET[ADDR_W-1:0];
    end else if (!r.address_strobe_n) begin
      pick_addr = r.addr[ADDR_W-1:0];
    end else if (!r.burst_advance_enable_n) begin
      pick_addr = c + 1'b1;
    end else begin
      pick_addr = c;
    end
  endfunction

  // after reset the port sees an idle, deselected read, so nothing is
  // written and nothing is driven until the host selects it
  function automatic dps_port_in_t quiet_inputs();
    dps_port_in_t q;
    q = '0;
    q.chip_select_active_low = 1'h1;
    q.write_n = 1'h1;
    q.burst_clear_n = 1'h1;
    q.address_strobe_n = 1'h1;
    q.burst_advance_enable_n = 1'h1;
    return q;
  endfunction

  // ----------------------------------------
  // next values
  // ----------------------------------------
  // every port works from its own registered copy, so the two never
  // interact except through the shared array
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      next_in[p] = port_in[p];
      sel[p] = !in_q[p].chip_select_active_low &&
               in_q[p].chip_select_active_high;
      acc[p] = pick_addr(in_q[p], cnt[p]);
      next_cnt[p] = acc[p];
      next_rdata[p] = mem[acc[p]];
      next_rvalid[p] = sel[p] && in_q[p].write_n;
      next_rlanes[p] = {!in_q[p].upper_byte_select_n,
                        !in_q[p].lower_byte_select_n};
      next_pdata[p] = rdata[p];
      next_pvalid[p] = rvalid[p];
      next_planes[p] = rlanes[p];
    end
  end

  always_ff @(posedge clk) begin
    for (int p = 0; p < NP; p++) begin
      if (reset) begin
        in_q[p] <= quiet_inputs();
        cnt[p] <= DPS_CNT_RESET[ADDR_W-1:0];
        rdata[p] <= DPS_DATA_RESET;
        rvalid[p] <= 1'h0;
        rlanes[p] <= 2'h0;
        pdata[p] <= DPS_DATA_RESET;
        pvalid[p] <= 1'h0;
        planes[p] <= 2'h0;
      end else begin
        in_q[p] <= next_in[p];
        cnt[p] <= next_cnt[p];
        rdata[p] <= next_rdata[p];
        rvalid[p] <= next_rvalid[p];
        rlanes[p] <= next_rlanes[p];
        pdata[p] <= next_pdata[p];
        pvalid[p] <= next_pvalid[p];
        planes[p] <= next_planes[p];
      end
    end
  end

  // ----------------------------------------
  // array writes
  // ----------------------------------------
  // the write is a single edge into the array, so its width never depends
  // on the clock high time; port 1 is applied last and so wins a same-address
  // collision, which callers must not rely on
  always_ff @(posedge clk) begin
    for (int p = 0; p < NP; p++) begin
      if (!reset && sel[p] && !in_q[p].write_n) begin
        if (!in_q[p].lower_byte_select_n) begin
          mem[acc[p]][DPS_LANE_W-1:0] <= in_q[p].wdata[DPS_LANE_W-1:0];
        end
        if (!in_q[p].upper_byte_select_n) begin
          mem[acc[p]][DW-1:DPS_LANE_W] <= in_q[p].wdata[DW-1:DPS_LANE_W];
        end
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // the output enable acts without the clock, as on the pins
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      if (in_q[p].output_mode_select == DPS_MODE_PIPE) begin
        port_out[p].data_out = pdata[p];
        port_out[p].data_oe = {2{pvalid[p] && !port_in[p].output_enable_n}}
                              & planes[p];
      end else begin
        port_out[p].data_out = rdata[p];
        port_out[p].data_oe = {2{rvalid[p] && !port_in[p].output_enable_n}}
                              & rlanes[p];
      end
      port_out[p].power_down = !sel[p];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  for (genvar g = 0; g < NP; g++) begin : g_chk
    // ----------------------------------------
    // counter, data path, select and output enable
    // ----------------------------------------
    clear_zero_a: assert property (
      !in_q[g].burst_clear_n |=> cnt[g] == '0
    ) else $error("counter not cleared");

    strobe_load_a: assert property (
      in_q[g].burst_clear_n && !in_q[g].address_strobe_n
      |=> cnt[g] == $past(in_q[g].addr[ADDR_W-1:0])
    ) else $error("strobe did not load counter");

    advance_step_a: assert property (
      in_q[g].burst_clear_n && in_q[g].address_strobe_n &&
      !in_q[g].burst_advance_enable_n
      |=> cnt[g] == ADDR_W'($past(cnt[g]) + 1'b1)
    ) else $error("counter did not step by one");

    input_capture_a: assert property (
      port_in[g].burst_clear_n && !port_in[g].address_strobe_n
      |-> ##2 cnt[g] == $past(port_in[g].addr[ADDR_W-1:0], 2)
    ) else $error("address not captured on edge");

    // array words are never reset, so read data compares use === and a word
    // that was never written still matches itself
    flow_data_a: assert property (
      in_q[g].output_mode_select == DPS_MODE_FLOW && sel[g] &&
      in_q[g].write_n
      |=> port_out[g].data_out === $past(mem[acc[g]])
    ) else $error("flow-through data wrong");

    pipe_delay_a: assert property (
      in_q[g].output_mode_select == DPS_MODE_PIPE &&
      $past(in_q[g].output_mode_select) == DPS_MODE_PIPE
      |-> port_out[g].data_out === $past(rdata[g])
    ) else $error("pipelined data not one cycle late");

    deselect_down_a: assert property (
      port_in[g].chip_select_active_low || !port_in[g].chip_select_active_high
      |=> port_out[g].power_down
    ) else $error("deselect did not power down");

    pipe_reactivate_a: assert property (
      in_q[g].output_mode_select && !sel[g]
      ##1 in_q[g].output_mode_select[*2]
      |-> port_out[g].data_oe == 2'h0
    ) else $error("pipelined outputs drove too early");

    lane_enable_a: assert property (
      port_out[g].data_oe != 2'h0 |-> !port_in[g].output_enable_n
    ) else $error("lane driven without output enable");

    // ----------------------------------------
    // further counter, select, lane and data checks
    // ----------------------------------------
    counter_hold_a: assert property (
      in_q[g].burst_clear_n && in_q[g].address_strobe_n &&
      in_q[g].burst_advance_enable_n
      |=> cnt[g] == $past(cnt[g])
    ) else $error("idle counter moved");

    flow_idle_a: assert property (
      in_q[g].output_mode_select == DPS_MODE_FLOW && !sel[g]
      |=> port_out[g].data_oe == 2'h0
    ) else $error("deselected flow access drove data");

    select_wake_a: assert property (
      !port_in[g].chip_select_active_low && port_in[g].chip_select_active_high
      |=> !port_out[g].power_down
    ) else $error("selected port stayed powered down");

    lower_read_a: assert property (
      in_q[g].output_mode_select == DPS_MODE_FLOW && sel[g] &&
      in_q[g].write_n && !in_q[g].lower_byte_select_n
      |=> port_in[g].output_enable_n || port_out[g].data_oe[0]
    ) else $error("lower lane not driven on read");

    upper_read_a: assert property (
      in_q[g].output_mode_select == DPS_MODE_FLOW && sel[g] &&
      in_q[g].write_n && !in_q[g].upper_byte_select_n
      |=> port_in[g].output_enable_n || port_out[g].data_oe[1]
    ) else $error("upper lane not driven on read");

    pipe_lane_a: assert property (
      in_q[g].output_mode_select == DPS_MODE_PIPE && sel[g] &&
      in_q[g].write_n && !in_q[g].lower_byte_select_n
      ##1 in_q[g].output_mode_select == DPS_MODE_PIPE
      |=> port_in[g].output_enable_n || port_out[g].data_oe[0]
    ) else $error("pipelined read not driven");

    pipe_data_a: assert property (
      in_q[g].output_mode_select == DPS_MODE_PIPE && sel[g] &&
      in_q[g].write_n
      ##1 in_q[g].output_mode_select == DPS_MODE_PIPE
      |=> port_out[g].data_out === $past(mem[acc[g]], 2)
    ) else $error("pipelined data not from the registered read");

    // port 0 is not judged while port 1 writes, since port 1 wins a clash
    lower_write_a: assert property (
      sel[g] && !in_q[g].write_n && !in_q[g].lower_byte_select_n &&
      !(g == 0 && sel[1] && !in_q[1].write_n)
      |=> mem[$past(acc[g])][DPS_LANE_W-1:0] ==
          $past(in_q[g].wdata[DPS_LANE_W-1:0])
    ) else $error("lower lane write lost");

    upper_write_a: assert property (
      sel[g] && !in_q[g].write_n && !in_q[g].upper_byte_select_n &&
      !(g == 0 && sel[1] && !in_q[1].write_n)
      |=> mem[$past(acc[g])][DW-1:DPS_LANE_W] ==
          $past(in_q[g].wdata[DW-1:DPS_LANE_W])
    ) else $error("upper lane write lost");
  end
endmodule // dps_sram

// >>> tb/dps_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// host model driving one memory port
// ----------------------------------------
module dps_host
  import dps_pkg::*;
#(
  parameter logic MODE = DPS_MODE_FLOW
) (
  input wire logic clk,
  output dps_pkg::dps_port_in_t pin
);
  dps_port_in_t idle_in;

  initial begin
    idle_in = '0;
    idle_in.output_mode_select = MODE;
    {idle_in.address_strobe_n, idle_in.burst_advance_enable_n,
     idle_in.burst_clear_n, idle_in.chip_select_active_low,
     idle_in.chip_select_active_high, idle_in.write_n,
     idle_in.lower_byte_select_n, idle_in.upper_byte_select_n} = 8'hEC;
    pin = idle_in;
  end

  // the output enable acts at once, so it is changed alone and given a
  // moment to settle before anyone looks
  task automatic hold_oe(input logic v);
    pin.output_enable_n = v;
    #1;
  endtask

  // one access per call, changed just after the edge; when not writing the
  // data lines flip so a stale value can never pass for a driven one
  task automatic put(input logic [15:0] a, input logic [17:0] d,
      input logic [7:0] c);
    @(posedge clk);
    #1;
    pin.addr = a;
    pin.wdata = c[2] ? ~pin.wdata : d;
    {pin.address_strobe_n, pin.burst_advance_enable_n, pin.burst_clear_n,
     pin.chip_select_active_low, pin.chip_select_active_high, pin.write_n,
     pin.lower_byte_select_n, pin.upper_byte_select_n} = c;
  endtask
endmodule // dps_host

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tb_top;
  import dps_pkg::*;
  // ----------------------------------------
  // clock, reset, hosts and memory
  // ----------------------------------------
  logic clk = 1'b0;
  logic reset = 1'b1;
  dps_port_in_t pin [DPS_NPORTS];
  dps_port_out_t pout [DPS_NPORTS];
  int errors = 0;
  int total_checks = 0;
  // control codes: strobe, advance, clear, cs low, cs high, write, lb, ub
  localparam logic [7:0] IDLE = 8'hEC, RD = 8'h6C, WR = 8'h68, AW = 8'hA8;
  localparam logic [7:0] AR = 8'hAC, WU = 8'h6A, RL = 8'h6D, CLR = 8'h4C;
  localparam logic [7:0] DSL = 8'h78, DSH = 8'h60, DSR = 8'h7C;

  always #4 clk = ~clk;

  dps_host #(.MODE(DPS_MODE_FLOW)) h0 (.clk(clk), .pin(pin[0]));
  dps_host #(.MODE(DPS_MODE_PIPE)) h1 (.clk(clk), .pin(pin[1]));
  dps_sram dut (.clk(clk), .reset(reset), .port_in(pin), .port_out(pout));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic acc(input int p, input logic [15:0] a,
      input logic [17:0] d, input logic [7:0] c);
    if (p == 0) h0.put(a, d, c);
    else h1.put(a, d, c);
  endtask

  task automatic idle(input int p, input int n);
    repeat (n) acc(p, 16'h0000, 18'h00000, IDLE);
  endtask

  // flow data shows two edges after the access is presented, pipe three
  task automatic rdx(input int p, input logic [15:0] a, input logic [7:0] c,
      input int lat);
    acc(p, a, 18'h00000, c);
    idle(p, lat);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_select();
    acc(0, 16'h0010, 18'h11111, WR);
    acc(0, 16'h0010, 18'h2AAAA, DSL);
    acc(0, 16'h0010, 18'h2AAAA, DSH);
    idle(0, 1);
    `CHK(pout[0].power_down, 1'b1)
    rdx(0, 16'h0010, RD, 2);
    `CHK(pout[0].data_out, 18'h11111)
    `CHK(pout[0].data_oe, 2'b11)
    h0.hold_oe(1'b1);
    `CHK(pout[0].data_oe, 2'b00)
    `CHK(pout[0].data_out, 18'h11111)
    h0.hold_oe(1'b0);
    $display("select test done");
  endtask

  task automatic t_lanes();
    acc(0, 16'h0030, 18'h12345, WR);
    acc(0, 16'h0030, 18'h2AAAA, WU);
    rdx(0, 16'h0030, RL, 2);
    `CHK(pout[0].data_out[8:0], 9'h145)
    `CHK(pout[0].data_oe, 2'b01)
    rdx(0, 16'h0030, RD, 2);
    `CHK(pout[0].data_out, 18'h2AB45)
    $display("lanes test done");
  endtask

  task automatic t_pipe();
    rdx(1, 16'h0010, RD, 3);
    `CHK(pout[1].data_out, 18'h11111)
    acc(1, 16'h0030, 18'h00000, RD);
    idle(1, 2);
    `CHK(pout[1].data_out, 18'h11111)
    idle(1, 1);
    `CHK(pout[1].data_out, 18'h2AB45)
    acc(1, 16'h0010, 18'h00000, DSR);
    acc(1, 16'h0010, 18'h00000, RD);
    `CHK(pout[1].power_down, 1'b1)
    idle(1, 2);
    `CHK(pout[1].power_down, 1'b0)
    `CHK(pout[1].data_oe, 2'b00)
    idle(1, 1);
    `CHK(pout[1].data_oe, 2'b11)
    `CHK(pout[1].data_out, 18'h11111)
    $display("pipe test done");
  endtask

  task automatic t_burst();
    acc(0, 16'hFFFE, 18'h00001, WR);
    acc(0, 16'h0000, 18'h00002, AW);
    acc(0, 16'h0000, 18'h00003, AW);
    acc(0, 16'hFFFE, 18'h00000, RD);
    acc(0, 16'h1234, 18'h00000, AR);
    acc(0, 16'h1234, 18'h00000, AR);
    `CHK(pout[0].data_out, 18'h00001)
    idle(0, 1);
    `CHK(pout[0].data_out, 18'h00002)
    idle(0, 1);
    `CHK(pout[0].data_out, 18'h00003)
    rdx(0, 16'h0005, CLR, 2);
    `CHK(pout[0].data_out, 18'h00003)
    $display("burst test done");
  endtask

  task automatic t_collide();
    fork
      acc(0, 16'h0020, 18'h0AAAA, WR);
      acc(1, 16'h0020, 18'h15555, WR);
    join
    fork
      idle(0, 1);
      idle(1, 1);
    join
    rdx(0, 16'h0020, RD, 2);
    `CHK(pout[0].data_out, 18'h15555)
    $display("collide test done");
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    #1;
    reset = 1'b0;
    t_select();
    t_lanes();
    t_pipe();
    t_burst();
    t_collide();
    give_verdict();
  end
endmodule // tb_top
